/* design/sei_pkg.sv */
// Constants and types shared by both ends of the serial EEPROM command link.
// Assumes one 20 MHz system clock on each end and a 7-bit address, 8-bit data array.
package sei_pkg;
  localparam int ADDR_W    = 7;
  localparam int DATA_W    = 8;
  localparam int MEM_DEPTH = 128;
  localparam int CMD_W     = 2 + ADDR_W + DATA_W;
  localparam int TIMER_W   = 19;
  localparam int FIFO_DEPTH = 32;

  // Opcodes and extended selections.
  localparam logic [1:0] OP_EXT        = 2'h0;
  localparam logic [1:0] OP_WRITE      = 2'h1;
  localparam logic [1:0] OP_READ       = 2'h2;
  localparam logic [1:0] OP_ERASE      = 2'h3;
  localparam logic [1:0] EXT_DISABLE   = 2'h0;
  localparam logic [1:0] EXT_WRITE_ALL = 2'h1;
  localparam logic [1:0] EXT_ERASE_ALL = 2'h2;
  localparam logic [1:0] EXT_ENABLE    = 2'h3;

  // Bits after the start bit, and clocks per frame including it.
  localparam logic [4:0] SHORT_BITS   = 5'h09;
  localparam logic [4:0] LONG_BITS    = 5'h11;
  localparam logic [4:0] SHORT_CLOCKS = 5'h0A;
  localparam logic [4:0] LONG_CLOCKS  = 5'h12;

  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // Timing; longest times round down, least times round up.
  localparam int CLOCK_PERIOD_NS   = 50;
  localparam int PROG_TIME_MS      = 6;
  localparam int ERASE_ALL_TIME_MS = 6;
  localparam int WRITE_ALL_TIME_MS = 15;
  localparam int PROG_CYCLES       = PROG_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int ERASE_ALL_CYCLES  = ERASE_ALL_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int WRITE_ALL_CYCLES  = WRITE_ALL_TIME_MS * 1000000 / CLOCK_PERIOD_NS;
  localparam int SCLK_HALF_NS      = 500;
  localparam int SCLK_HALF_CYCLES  = (SCLK_HALF_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;

  typedef enum {DEV_IDLE, DEV_CMD, DEV_READ, DEV_BUSY} sei_dev_state_type;
  typedef enum {H_IDLE, H_SHIFT, H_READ, H_GAP, H_POLL, H_CLEAR, H_END} sei_host_state_type;
  typedef enum logic [2:0] {
    CMD_READ, CMD_WRITE, CMD_ERASE, CMD_ERASE_ALL, CMD_WRITE_ALL, CMD_PROG_ENABLE, CMD_PROG_DISABLE
  } sei_cmd_type;
endpackage

/* design/sei_if.sv */
// Four-wire link between the host end and the device end.
// The serial output is released by its enable; a pull-up on the board holds serial_out_line high meanwhile.
`timescale 1ns/100ps
interface sei_if;
  logic cs;
  logic sclk;
  logic serial_in;
  logic serial_out;
  logic serial_out_oe_n;
  wire  serial_out_line;

  // A released line reads high, so a host polling after an ignored programming command sees ready.
  assign serial_out_line = serial_out_oe_n ? 1'b1 : serial_out;

  modport dev  (input cs, sclk, serial_in, output serial_out, serial_out_oe_n);
  modport host (output cs, sclk, serial_in, input serial_out_line);
endinterface

/* design/sei_fifo.sv */
// Synchronous FIFO with valid and ready on both sides.
// Assumes both sides on the same clock.
`timescale 1ns/100ps
module sei_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  // System
  input  wire logic             clock,
  input  wire logic             resetn,
  // Fill side
  input  wire logic             in_valid,
  output wire logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output wire logic             out_valid,
  input  wire logic             out_ready,
  output wire logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0]      wr_ptr_reg;
  logic [PW:0]      rd_ptr_reg;

  wire empty = wr_ptr_reg == rd_ptr_reg;
  wire full  = (wr_ptr_reg[PW] != rd_ptr_reg[PW]) && (wr_ptr_reg[PW-1:0] == rd_ptr_reg[PW-1:0]);
  wire push  = in_valid && !full;
  wire pop   = out_valid && out_ready;

  assign in_ready  = !full;
  assign out_valid = !empty;
  assign out_data  = mem[rd_ptr_reg[PW-1:0]];

  always_ff @(posedge clock) begin
    if (push) begin
      mem[wr_ptr_reg[PW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      if (push) wr_ptr_reg <= wr_ptr_reg + 1'b1;
      if (pop) rd_ptr_reg <= rd_ptr_reg + 1'b1;
    end
  end
endmodule // sei_fifo

/* design/sei_device.sv */
// Device end of the serial EEPROM link: command framing, 128 x 8 array, self-timed programming.
// Assumes the link pins come from another clock domain and are synchronised here.
`timescale 1ns/100ps
module sei_device #(
  parameter int unsigned WRITE_CYCLES     = sei_pkg::PROG_CYCLES,
  parameter int unsigned ERASE_ALL_CYCLES = sei_pkg::ERASE_ALL_CYCLES,
  parameter int unsigned WRITE_ALL_CYCLES = sei_pkg::WRITE_ALL_CYCLES
) (
  // System
  input  wire logic clock,
  input  wire logic resetn,
  // Link
  sei_if.dev        link,
  // Status
  output wire logic busy,
  output wire logic prog_enabled,
  output wire logic standby
);
  import sei_pkg::*;

  sei_dev_state_type      state_reg;
  sei_dev_state_type      state_next;
  logic [2:0]             meta_reg;
  logic [2:0]             sync_reg;
  logic                   sclk_d_reg;
  logic                   cs_d_reg;
  logic [CMD_W-1:0]       cmd_reg;
  logic [4:0]             cnt_reg;
  logic [ADDR_W-1:0]      rd_addr_reg;
  logic [DATA_W-1:0]      rd_sh_reg;
  logic [2:0]             rd_cnt_reg;
  logic                   out_reg;
  logic                   so_reg;
  logic                   oe_n_reg;
  logic                   prog_en_reg;
  logic                   pending_reg;
  logic                   arm_reg;
  logic [TIMER_W-1:0]     timer_reg;
  logic [DATA_W-1:0]      mem [MEM_DEPTH];

  // Synchronised pins; bit 2 chip select, bit 1 clock, bit 0 serial input.
  wire cs_s       = sync_reg[2];
  wire si_s       = sync_reg[0];
  wire sclk_rise  = sync_reg[1] && !sclk_d_reg;
  wire cs_fall    = cs_d_reg && !cs_s;
  wire in_idle    = state_reg == DEV_IDLE;
  wire in_cmd     = state_reg == DEV_CMD;
  wire in_read    = state_reg == DEV_READ;
  wire in_busy    = state_reg == DEV_BUSY;
  wire start_seen = sclk_rise && cs_s && si_s;

  // Command fields sit at fixed places, filled from the top down.
  wire [1:0]        op        = cmd_reg[CMD_W-1 -: 2];
  wire [1:0]        ext       = cmd_reg[CMD_W-3 -: 2];
  wire [ADDR_W-1:0] addr      = cmd_reg[CMD_W-3 -: ADDR_W];
  wire [DATA_W-1:0] data      = cmd_reg[DATA_W-1:0];
  wire              is_ext    = op == OP_EXT;
  wire              write_all = is_ext && (ext == EXT_WRITE_ALL);
  wire              erase_all = is_ext && (ext == EXT_ERASE_ALL);
  wire              en_cmd    = is_ext && (ext == EXT_ENABLE);
  wire              dis_cmd   = is_ext && (ext == EXT_DISABLE);
  wire              long_cmd  = (op == OP_WRITE) || write_all;
  wire [4:0]        need      = long_cmd ? LONG_BITS : SHORT_BITS;
  wire              complete  = cnt_reg == need;
  wire [4:0]        bit_idx   = 5'(CMD_W - 1) - cnt_reg;
  wire              take_bit  = in_cmd && sclk_rise && !complete;
  wire              read_go   = take_bit && (op == OP_READ) && (cnt_reg == SHORT_BITS - 5'h01);
  wire              execute   = in_cmd && cs_fall && complete;
  wire              is_prog   = (op != OP_READ) && !en_cmd && !dis_cmd;
  wire              do_prog   = execute && is_prog && prog_en_reg;
  wire [DATA_W-1:0] wr_byte   = ((op == OP_WRITE) || write_all) ? data : ERASED_BYTE;
  wire [DATA_W-1:0] read_byte = mem[rd_addr_reg];
  wire [TIMER_W-1:0] load_val = write_all ? TIMER_W'(WRITE_ALL_CYCLES - 1) :
                                erase_all ? TIMER_W'(ERASE_ALL_CYCLES - 1) :
                                TIMER_W'(WRITE_CYCLES - 1);
  wire              pending_next = do_prog || (pending_reg && !(arm_reg && cs_fall));
  wire              drive        = cs_s && (in_read || in_busy || pending_reg);
  wire              so_next      = in_read ? out_reg : !in_busy;

  assign link.serial_out      = so_reg;
  assign link.serial_out_oe_n = oe_n_reg;
  assign busy                 = in_busy;
  assign prog_enabled         = prog_en_reg;
  assign standby              = !cs_s;

  // The first stage feeds only the second; edges are taken from the second on.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      meta_reg   <= '0;
      sync_reg   <= '0;
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b0;
    end else begin
      meta_reg   <= {link.cs, link.sclk, link.serial_in};
      sync_reg   <= meta_reg;
      sclk_d_reg <= sync_reg[1];
      cs_d_reg   <= sync_reg[2];
    end
  end

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      DEV_IDLE: if (start_seen) state_next = DEV_CMD;
      DEV_CMD: begin
        if (read_go) state_next = DEV_READ;
        else if (cs_fall) state_next = do_prog ? DEV_BUSY : DEV_IDLE;
      end
      DEV_READ: if (cs_fall) state_next = DEV_IDLE;
      DEV_BUSY: if (timer_reg == '0) state_next = DEV_IDLE;
      default: state_next = DEV_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= DEV_IDLE;
      timer_reg <= '0;
    end else begin
      state_reg <= state_next;
      if (do_prog) timer_reg <= load_val;
      else if (in_busy && timer_reg != '0) timer_reg <= timer_reg - 1'b1;
    end
  end

  // Extra clocks after the last required bit are ignored rather than shifted.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      cmd_reg <= '0;
      cnt_reg <= '0;
    end else if (in_idle && start_seen) begin
      cmd_reg <= '0;
      cnt_reg <= '0;
    end else if (take_bit) begin
      cmd_reg[bit_idx] <= si_s;
      cnt_reg          <= cnt_reg + 5'h01;
    end
  end

  // A read streams on past each byte into the next location while select stays high.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rd_addr_reg <= '0;
      rd_sh_reg   <= '0;
      rd_cnt_reg  <= '0;
      out_reg     <= 1'b0;
    end else if (read_go) begin
      rd_addr_reg <= {addr[ADDR_W-1:1], si_s};
      rd_cnt_reg  <= '0;
      out_reg     <= 1'b0;
    end else if (in_read && sclk_rise) begin
      rd_cnt_reg <= rd_cnt_reg + 3'h1;
      if (rd_cnt_reg == '0) begin
        out_reg     <= read_byte[DATA_W-1];
        rd_sh_reg   <= {read_byte[DATA_W-2:0], 1'b0};
        rd_addr_reg <= rd_addr_reg + 7'h01;
      end else begin
        out_reg   <= rd_sh_reg[DATA_W-1];
        rd_sh_reg <= {rd_sh_reg[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Enable state survives everything but a disable command or reset.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      prog_en_reg <= 1'b0;
      pending_reg <= 1'b0;
      arm_reg     <= 1'b0;
    end else begin
      if (execute && en_cmd) prog_en_reg <= 1'b1;
      else if (execute && dis_cmd) prog_en_reg <= 1'b0;
      pending_reg <= pending_next;
      if (cs_fall) arm_reg <= 1'b0;
      else if (in_idle && start_seen && pending_reg) arm_reg <= 1'b1;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      so_reg   <= 1'b0;
      oe_n_reg <= 1'b1;
    end else begin
      so_reg   <= so_next;
      oe_n_reg <= !drive;
    end
  end

  // Reset stands in for power-up and leaves the array erased.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < MEM_DEPTH; i++) mem[i] <= ERASED_BYTE;
    end else if (do_prog) begin
      for (int i = 0; i < MEM_DEPTH; i++) begin
        if (is_ext || ADDR_W'(i) == addr) mem[i] <= wr_byte;
      end
    end
  end
endmodule // sei_device

/* design/sei_host.sv */
// Host end of the serial EEPROM link: frames commands, polls status, buffers read bytes.
// Assumes the device output returns from another domain and is synchronised here.
`timescale 1ns/100ps
module sei_host #(
  parameter int HALF_CYCLES = sei_pkg::SCLK_HALF_CYCLES,
  parameter int FIFO_DEPTH  = sei_pkg::FIFO_DEPTH
) (
  // System
  input  wire logic                       clock,
  input  wire logic                       resetn,
  // Link
  sei_if.host                             link,
  // Command
  input  wire logic                       cmd_valid,
  output wire logic                       cmd_ready,
  input  wire sei_pkg::sei_cmd_type       cmd_op,
  input  wire logic [sei_pkg::ADDR_W-1:0] cmd_addr,
  input  wire logic [sei_pkg::DATA_W-1:0] cmd_data,
  input  wire logic [7:0]                 cmd_len,
  // Read data
  output wire logic                       rd_valid,
  input  wire logic                       rd_ready,
  output wire logic [sei_pkg::DATA_W-1:0] rd_data,
  // Status
  output wire logic                       host_busy
);
  import sei_pkg::*;

  sei_host_state_type      state_reg;
  logic [7:0]              div_reg;
  logic                    cs_reg;
  logic                    sclk_reg;
  logic                    si_reg;
  logic [LONG_CLOCKS-1:0]  tx_reg;
  logic [4:0]              bits_reg;
  logic [DATA_W-1:0]       rx_reg;
  logic [2:0]              rxcnt_reg;
  logic [7:0]              bytes_reg;
  logic                    push_reg;
  logic                    read_reg;
  logic                    prog_reg;
  logic                    so_meta_reg;
  logic                    so_sync_reg;
  wire                     fifo_in_ready;

  function automatic logic [LONG_CLOCKS-1:0] frame_of(sei_cmd_type op, logic [ADDR_W-1:0] a,
                                                       logic [DATA_W-1:0] d);
    case (op)
      CMD_READ:         frame_of = {1'b1, OP_READ, a, 8'h00};
      CMD_WRITE:        frame_of = {1'b1, OP_WRITE, a, d};
      CMD_ERASE:        frame_of = {1'b1, OP_ERASE, a, 8'h00};
      CMD_ERASE_ALL:    frame_of = {1'b1, OP_EXT, EXT_ERASE_ALL, 13'h0000};
      CMD_WRITE_ALL:    frame_of = {1'b1, OP_EXT, EXT_WRITE_ALL, 5'h00, d};
      CMD_PROG_ENABLE:  frame_of = {1'b1, OP_EXT, EXT_ENABLE, 13'h0000};
      default:          frame_of = {1'b1, OP_EXT, EXT_DISABLE, 13'h0000};
    endcase
  endfunction

  wire [LONG_CLOCKS-1:0] frame   = frame_of(cmd_op, cmd_addr, cmd_data);
  wire                   is_long = (cmd_op == CMD_WRITE) || (cmd_op == CMD_WRITE_ALL);
  wire                   is_prog = (cmd_op != CMD_READ) && (cmd_op != CMD_PROG_ENABLE) &&
                                   (cmd_op != CMD_PROG_DISABLE);
  wire                   tick    = div_reg == 8'(HALF_CYCLES - 1);
  wire                   stall   = (state_reg == H_READ) && !sclk_reg && push_reg;
  wire                   accept  = cmd_valid && cmd_ready;

  assign cmd_ready      = (state_reg == H_IDLE) && !push_reg;
  assign host_busy      = state_reg != H_IDLE;
  assign link.cs        = cs_reg;
  assign link.sclk      = sclk_reg;
  assign link.serial_in = si_reg;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      so_meta_reg <= 1'b0;
      so_sync_reg <= 1'b0;
      div_reg     <= '0;
    end else begin
      so_meta_reg <= link.serial_out_line;
      so_sync_reg <= so_meta_reg;
      if (accept || (tick && !stall)) div_reg <= '0;
      else if (!tick) div_reg <= div_reg + 8'h01;
    end
  end

  // Select rises with the clock low, so a start cannot be mistaken at that moment.
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= H_IDLE;
      cs_reg    <= 1'b0;
      sclk_reg  <= 1'b0;
      si_reg    <= 1'b0;
      tx_reg    <= '0;
      bits_reg  <= '0;
      rx_reg    <= '0;
      rxcnt_reg <= '0;
      bytes_reg <= '0;
      push_reg  <= 1'b0;
      read_reg  <= 1'b0;
      prog_reg  <= 1'b0;
    end else begin
      if (push_reg && fifo_in_ready) push_reg <= 1'b0;
      case (state_reg)
        H_IDLE: if (accept) begin
          cs_reg    <= 1'b1;
          si_reg    <= frame[LONG_CLOCKS-1];
          tx_reg    <= {frame[LONG_CLOCKS-2:0], 1'b0};
          bits_reg  <= is_long ? LONG_CLOCKS : SHORT_CLOCKS;
          bytes_reg <= cmd_len;
          read_reg  <= cmd_op == CMD_READ;
          prog_reg  <= is_prog;
          state_reg <= H_SHIFT;
        end
        H_SHIFT: if (tick) begin
          sclk_reg <= !sclk_reg;
          if (!sclk_reg) bits_reg <= bits_reg - 5'h01;
          else if (bits_reg != '0) begin
            si_reg <= tx_reg[LONG_CLOCKS-1];
            tx_reg <= {tx_reg[LONG_CLOCKS-2:0], 1'b0};
          end else if (read_reg) begin
            rxcnt_reg <= '0;
            state_reg <= H_READ;
          end else begin
            cs_reg    <= 1'b0;
            si_reg    <= 1'b0;
            state_reg <= prog_reg ? H_GAP : H_END;
          end
        end
        H_READ: if (tick && !stall) begin
          sclk_reg <= !sclk_reg;
          if (sclk_reg) begin
            rx_reg    <= {rx_reg[DATA_W-2:0], so_sync_reg};
            rxcnt_reg <= rxcnt_reg + 3'h1;
            if (rxcnt_reg == 3'h7) begin
              push_reg  <= 1'b1;
              bytes_reg <= bytes_reg - 8'h01;
              if (bytes_reg == '0) begin
                cs_reg    <= 1'b0;
                state_reg <= H_END;
              end
            end
          end
        end
        H_GAP: if (tick) begin
          cs_reg    <= 1'b1;
          state_reg <= H_POLL;
        end
        H_POLL: if (tick && so_sync_reg) begin
          si_reg    <= 1'b1;
          state_reg <= H_CLEAR;
        end
        H_CLEAR: if (tick) begin
          sclk_reg <= !sclk_reg;
          if (sclk_reg) begin
            si_reg    <= 1'b0;
            cs_reg    <= 1'b0;
            state_reg <= H_END;
          end
        end
        H_END: if (tick) state_reg <= H_IDLE;
        default: state_reg <= H_IDLE;
      endcase
    end
  end

  sei_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .resetn    (resetn),
    .in_valid  (push_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (rx_reg),
    .out_valid (rd_valid),
    .out_ready (rd_ready),
    .out_data  (rd_data)
  );
endmodule // sei_host

/* test/sei_link_sva.sv */
// Concurrent checks on the four-wire link between the host end and the device end.
// Assumes one clock for both ends; the device busy and standby outputs are wired in beside the link.
`timescale 1ns/100ps
module sei_link_sva #(
  parameter int BUSY_MAX = 60
) (
  // System
  input wire logic clock,
  input wire logic resetn,
  // Link
  input wire logic cs,
  input wire logic sclk,
  input wire logic serial_in,
  input wire logic serial_out,
  input wire logic serial_out_oe_n,
  // Device status
  input wire logic busy,
  input wire logic standby
);
  default clocking dflt @(posedge clock); endclocking
  default disable iff (!resetn);

  // A counter bounds the self-timed cycle, which is far too long for a repetition.
  logic [19:0] busy_cnt_reg;
  wire  [19:0] busy_cnt_next = busy ? busy_cnt_reg + 20'h0_0001 : 20'h0_0000;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      busy_cnt_reg <= 20'h0_0000;
    end else begin
      busy_cnt_reg <= busy_cnt_next;
    end
  end

  // The device sees the select pin through synchronisers, so release may lag the pin by a few clocks.
  chk_drive_needs_select:
    assert property (!serial_out_oe_n |-> (cs || $past(cs) || $past(cs, 2) || $past(cs, 3) || $past(cs, 4)))
      else $error("serial output driven while chip select is low");
  chk_drive_starts_selected:
    assert property ($fell(serial_out_oe_n) |-> cs && $past(cs, 2))
      else $error("serial output drive began without chip select");
  chk_select_fall_release:
    assert property ($fell(cs) |-> ##[1:5] serial_out_oe_n)
      else $error("serial output not released after chip select fell");
  chk_busy_drives_low:
    assert property (busy && !serial_out_oe_n |-> !serial_out)
      else $error("status not low while programming");
  chk_ready_drives_high:
    assert property ($fell(busy) && !serial_out_oe_n |-> ##[0:3] (serial_out || serial_out_oe_n))
      else $error("status not high once programming ended");
  chk_busy_after_select:
    assert property ($rose(busy) |-> !cs && !$past(cs, 2))
      else $error("programming cycle began while chip select was high");
  chk_cycle_time_bound:
    assert property (busy_cnt_reg <= BUSY_MAX)
      else $error("self-timed cycle ran past its limit");
  chk_select_rise_quiet:
    assert property ($rose(cs) |-> !(sclk && serial_in))
      else $error("chip select rose with clock and input both high");
  chk_clock_idle_low:
    assert property (!cs |-> !sclk)
      else $error("serial clock high outside a frame");
  chk_input_stable_high:
    assert property (sclk && $past(sclk) |-> $stable(serial_in))
      else $error("serial input changed while clock high");
  chk_clock_high_width:
    assert property ($rose(sclk) |-> sclk [*8])
      else $error("serial clock high phase too short");
  chk_select_ends_standby:
    assert property (cs && $past(cs) && $past(cs, 2) && $past(cs, 3) && $past(cs, 4) |-> !standby)
      else $error("device still in standby with chip select high");

  cov_status_poll: cover property ($fell(busy) && !serial_out_oe_n);
  cov_output_drive: cover property ($fell(serial_out_oe_n));
  cov_frame_start: cover property ($rose(cs) ##1 cs [*8]);
endmodule // sei_link_sva

/* test/tb_top.sv */
// Self-checking bench: host end and device end joined by one link, driven through the host command port.
// Assumes short programming times set through parameters so the run stays brief.
`timescale 1ns/100ps
module tb_top;
  import sei_pkg::*;
  localparam int WR_CYC = 40;
  localparam int WA_CYC = 60;

  logic              clock      = 1'b0;
  logic              resetn     = 1'b0;
  logic              cmd_valid  = 1'b0;
  sei_cmd_type       cmd_op     = CMD_READ;
  logic [ADDR_W-1:0] cmd_addr   = '0;
  logic [DATA_W-1:0] cmd_data   = '0;
  logic [7:0]        cmd_len    = 8'h00;
  logic              rd_ready   = 1'b0;
  logic              cmd_ready, rd_valid, host_busy, busy, prog_enabled, standby;
  logic [DATA_W-1:0] rd_data;
  int                n_fail     = 0;
  int                n_compared = 0;

  sei_if lnk ();
  sei_device #(.WRITE_CYCLES(WR_CYC), .ERASE_ALL_CYCLES(WR_CYC), .WRITE_ALL_CYCLES(WA_CYC)) i_sei_device (
    .clock(clock), .resetn(resetn), .link(lnk), .busy(busy), .prog_enabled(prog_enabled), .standby(standby));
  sei_host #(.HALF_CYCLES(10), .FIFO_DEPTH(32)) i_sei_host (
    .clock(clock), .resetn(resetn), .link(lnk), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data), .cmd_len(cmd_len), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_data(rd_data), .host_busy(host_busy));
  sei_link_sva #(.BUSY_MAX(WA_CYC)) i_sei_link_sva (
    .clock(clock), .resetn(resetn), .cs(lnk.cs), .sclk(lnk.sclk), .serial_in(lnk.serial_in),
    .serial_out(lnk.serial_out), .serial_out_oe_n(lnk.serial_out_oe_n), .busy(busy), .standby(standby));

  always #25 clock = ~clock;

  task automatic give_verdict();
    if (n_fail == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic send(input sei_cmd_type op, input logic [6:0] addr, input logic [7:0] data, input logic [7:0] len);
    int k;
    k = 0;
    @(posedge clock);
    cmd_op <= op;
    cmd_addr <= addr;
    cmd_data <= data;
    cmd_len <= len;
    cmd_valid <= 1'b1;
    do begin
      @(posedge clock);
      k++;
    end while (cmd_ready !== 1'b1 && k < 100);
    cmd_valid <= 1'b0;
    if (k >= 100) check(8'h00, 8'h01);
  endtask

  // Programming commands finish only after the host has polled ready and cleared the status.
  task automatic wait_idle();
    int k;
    k = 0;
    @(posedge clock);
    while (host_busy !== 1'b0 && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20000) check(8'h00, 8'h01);
  endtask

  task automatic prog(input sei_cmd_type op, input logic [6:0] addr, input logic [7:0] data);
    send(op, addr, data, 8'h00);
    wait_idle();
  endtask

  // Reads n bytes; the first must be e0 and the rest e1. A hold keeps the FIFO undrained meanwhile.
  task automatic rd_chk(input logic [6:0] addr, input int n, input logic [7:0] e0, input logic [7:0] e1,
                        input int hold);
    int i;
    int k;
    i = 0;
    k = 0;
    send(CMD_READ, addr, 8'h00, 8'(n - 1));
    repeat (hold) @(posedge clock);
    if (hold > 0) check({7'h00, host_busy}, 8'h01);
    rd_ready <= 1'b1;
    while (i < n && k < 4000) begin
      @(posedge clock);
      k++;
      if (rd_valid === 1'b1) begin
        check(rd_data, (i == 0) ? e0 : e1);
        i++;
        k = 0;
      end
    end
    rd_ready <= 1'b0;
    if (i < n) check(8'h00, 8'h01);
    wait_idle();
  endtask

  initial begin
    repeat (10) @(posedge clock);
    resetn <= 1'b1;
    @(posedge clock);
    check({6'h00, standby, prog_enabled}, 8'h02);
    prog(CMD_WRITE, 7'h05, 8'h3C);
    rd_chk(7'h05, 1, 8'hFF, 8'hFF, 0);
    prog(CMD_PROG_ENABLE, 7'h00, 8'h00);
    check({7'h00, prog_enabled}, 8'h01);
    prog(CMD_WRITE, 7'h7F, 8'hA5);
    prog(CMD_WRITE, 7'h00, 8'h5A);
    prog(CMD_WRITE, 7'h05, 8'h3C);
    rd_chk(7'h7F, 2, 8'hA5, 8'h5A, 0);
    rd_chk(7'h05, 1, 8'h3C, 8'h3C, 0);
    prog(CMD_ERASE, 7'h05, 8'h00);
    rd_chk(7'h05, 1, 8'hFF, 8'hFF, 0);
    prog(CMD_WRITE_ALL, 7'h00, 8'h69);
    rd_chk(7'h7E, 4, 8'h69, 8'h69, 0);
    prog(CMD_ERASE_ALL, 7'h00, 8'h00);
    prog(CMD_PROG_DISABLE, 7'h00, 8'h00);
    check({7'h00, prog_enabled}, 8'h00);
    prog(CMD_WRITE, 7'h03, 8'h11);
    rd_chk(7'h03, 34, 8'hFF, 8'hFF, 6000);
    give_verdict();
  end

  initial begin
    repeat (60000) @(posedge clock);
    n_fail++;
    give_verdict();
  end
endmodule // tb_top
